// ---- verilog/cfm_pkg.sv ----
// Constants shared by the frequency and pulse-width counter channel
package cfm_pkg;

  // Clock and output pulse timing
  localparam int unsigned CLK_PERIOD_NS  = 5;
  localparam int unsigned OUT_PULSE_NS   = 1740;
  localparam int unsigned OUT_PULSE_CYC  = OUT_PULSE_NS / CLK_PERIOD_NS;
  localparam int unsigned OUT_PULSE_W    = 9;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_CONST   = 8'h04;
  localparam logic [7:0] OFF_RDBACK  = 8'h08;
  localparam logic [7:0] OFF_TRIG    = 8'h0C;
  localparam logic [7:0] OFF_INT_EN  = 8'h10;
  localparam logic [7:0] OFF_INT_ST  = 8'h14;

  // Control field positions
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_OPOL_BIT = 3;
  localparam int unsigned CTRL_GATE_LSB = 4;
  localparam int unsigned CTRL_EVT_LSB  = 6;
  localparam int unsigned CTRL_TRIG_LSB = 8;
  localparam int unsigned CTRL_SEL_LSB  = 10;
  localparam logic [15:0] CTRL_RST      = 16'h0000;
  localparam logic [15:0] CTRL_MASK     = 16'h1FFF;

  // Field codes
  localparam logic [2:0] MODE_FREQ = 3'h4;
  localparam logic [2:0] MODE_PW   = 3'h5;
  localparam logic [2:0] SEL_FREQ  = 3'h7;
  localparam logic [1:0] POL_LOW   = 2'h1;
  localparam logic [1:0] POL_HIGH  = 2'h2;

  // Counting clock dividers for select codes 000..100
  localparam logic [7:0] DIV_SEL0 = 8'h66;
  localparam logic [7:0] DIV_SEL1 = 8'h33;
  localparam logic [7:0] DIV_SEL2 = 8'h1A;
  localparam logic [7:0] DIV_SEL3 = 8'h0D;
  localparam logic [7:0] DIV_SEL4 = 8'h03;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARMED = 2'b01,
    ST_COUNT = 2'b10
  } cfm_state_t;

endpackage

// ---- verilog/cfm_tick_if.sv ----
// Counting clock select and tick between channel and divider
`timescale 1ns/1ps
interface cfm_tick_if;
  logic [2:0] sel;
  logic       tick;
  modport gen  (input sel, output tick);
  modport user (output sel, input tick);
endinterface

// ---- verilog/cfm_tick_gen.sv ----
// Counting clock enable divider for pulse-width measurement
`timescale 1ns/1ps
module cfm_tick_gen (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Select and tick
  cfm_tick_if.gen   tk
);

  logic [7:0] div_lim;
  logic       sel_ok;
  logic [7:0] div_q;
  logic       tick_q;

  always_comb begin
    sel_ok  = 1'b1;
    div_lim = cfm_pkg::DIV_SEL0;
    unique case (tk.sel)
      3'h0: div_lim = cfm_pkg::DIV_SEL0;
      3'h1: div_lim = cfm_pkg::DIV_SEL1;
      3'h2: div_lim = cfm_pkg::DIV_SEL2;
      3'h3: div_lim = cfm_pkg::DIV_SEL3;
      3'h4: div_lim = cfm_pkg::DIV_SEL4;
      default: sel_ok = 1'b0;
    endcase
  end

  // Ratios are rounded; the base clock is not an exact multiple
  always_ff @(posedge ref_clk) begin
    if (rst || !sel_ok) begin
      div_q  <= 8'h00;
      tick_q <= 1'b0;
    end else if (div_q >= div_lim - 8'h01) begin
      div_q  <= 8'h00;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 8'h01;
      tick_q <= 1'b0;
    end
  end

  assign tk.tick = tick_q;

endmodule

// ---- verilog/cfm_counter.sv ----
// Frequency and pulse-width measurement counter channel
`timescale 1ns/1ps
module cfm_counter #(
  parameter int unsigned CNT_W = 28
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Field inputs
  input  wire logic        gate_measure_input,
  input  wire logic        event_signal_input,
  input  wire logic        external_trigger_input,
  // Field output and interrupt
  output logic             counter_out,
  output logic             irq
);

  // Registers
  logic [15:0]          ctrl_q;
  logic [31:0]          const_q;
  logic                 int_en_q;
  logic                 int_st_q;
  logic [CNT_W-1:0]     cnt_q;
  cfm_pkg::cfm_state_t  state_q;
  logic [cfm_pkg::OUT_PULSE_W-1:0] pulse_cnt_q;
  logic                 gate_prev_q;
  logic                 evt_prev_q;
  logic                 trig_prev_q;
  // Bus state
  logic                 aw_have_q;
  logic [7:0]           aw_addr_q;
  logic                 w_have_q;
  logic [31:0]          w_data_q;
  logic [3:0]           w_strb_q;
  logic                 bvalid_q;
  logic [1:0]           bresp_q;
  logic                 rvalid_q;
  logic [31:0]          rdata_q;
  logic [1:0]           rresp_q;
  // Decoded fields
  logic [2:0]           mode;
  logic [2:0]           sel;
  logic [1:0]           gate_pol;
  logic [1:0]           evt_pol;
  logic [1:0]           trig_pol;
  logic                 freq_mode;
  logic                 pw_mode;
  logic                 gate_act;
  logic                 gate_start;
  logic                 gate_end;
  logic                 evt_edge;
  logic                 ext_trig;
  logic                 wr_fire;
  logic                 sw_trig;
  logic                 const_wr;
  logic                 done;
  logic                 cnt_full;
  logic                 cnt_tick;
  logic [31:0]          wmask;
  logic [31:0]          ctrl_new;
  logic [31:0]          const_new;

  cfm_tick_if tk ();
  cfm_tick_gen u_tick (
    .ref_clk (ref_clk),
    .rst     (rst),
    .tk      (tk)
  );

  // Byte lanes of the held write data that software enabled
  assign wmask     = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                      {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  assign ctrl_new  = ({16'h0000, ctrl_q} & ~wmask) | (w_data_q & wmask);
  assign const_new = (const_q & ~wmask) | (w_data_q & wmask);

  // Field decode
  assign mode     = ctrl_q[cfm_pkg::CTRL_MODE_LSB +: 3];
  assign sel      = ctrl_q[cfm_pkg::CTRL_SEL_LSB +: 3];
  assign gate_pol = ctrl_q[cfm_pkg::CTRL_GATE_LSB +: 2];
  assign evt_pol  = ctrl_q[cfm_pkg::CTRL_EVT_LSB +: 2];
  assign trig_pol = ctrl_q[cfm_pkg::CTRL_TRIG_LSB +: 2];

  assign freq_mode = (mode == cfm_pkg::MODE_FREQ) &&
                     (sel == cfm_pkg::SEL_FREQ);
  assign pw_mode   = (mode == cfm_pkg::MODE_PW);

  // Gate level qualification, shared by both modes
  always_comb begin
    unique case (gate_pol)
      cfm_pkg::POL_LOW:  gate_act = !gate_measure_input;
      cfm_pkg::POL_HIGH: gate_act = gate_measure_input;
      default:           gate_act = 1'b0;
    endcase
  end

  assign gate_start = gate_act && !gate_prev_q;
  assign gate_end   = !gate_act && gate_prev_q;

  // Event edge that closes a counted pulse of the chosen level
  always_comb begin
    unique case (evt_pol)
      cfm_pkg::POL_LOW:  evt_edge = event_signal_input && !evt_prev_q;
      cfm_pkg::POL_HIGH: evt_edge = !event_signal_input && evt_prev_q;
      default:           evt_edge = 1'b0;
    endcase
  end

  // External trigger edge
  always_comb begin
    unique case (trig_pol)
      cfm_pkg::POL_LOW:
        ext_trig = !external_trigger_input && trig_prev_q;
      cfm_pkg::POL_HIGH:
        ext_trig = external_trigger_input && !trig_prev_q;
      default:
        ext_trig = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      gate_prev_q <= 1'b0;
      evt_prev_q  <= 1'b0;
      trig_prev_q <= 1'b0;
    end else begin
      gate_prev_q <= gate_act;
      evt_prev_q  <= event_signal_input;
      trig_prev_q <= external_trigger_input;
    end
  end

  // Bus write handshake; address and data taken in either order
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign wr_fire       = aw_have_q && w_have_q && !bvalid_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= cfm_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      unique case (aw_addr_q)
        cfm_pkg::OFF_CTRL, cfm_pkg::OFF_CONST, cfm_pkg::OFF_RDBACK,
        cfm_pkg::OFF_TRIG, cfm_pkg::OFF_INT_EN, cfm_pkg::OFF_INT_ST:
          bresp_q <= cfm_pkg::RESP_OKAY;
        default:
          bresp_q <= cfm_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  assign sw_trig  = wr_fire && (aw_addr_q == cfm_pkg::OFF_TRIG) &&
                    w_strb_q[0] && w_data_q[0];
  assign const_wr = wr_fire && (aw_addr_q == cfm_pkg::OFF_CONST);

  // Writable registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q <= cfm_pkg::CTRL_RST;
    end else if (wr_fire && aw_addr_q == cfm_pkg::OFF_CTRL) begin
      ctrl_q <= ctrl_new[15:0] & cfm_pkg::CTRL_MASK;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      const_q <= 32'h0000_0000;
    end else if (const_wr) begin
      const_q <= const_new;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      int_en_q <= 1'b0;
    end else if (wr_fire && aw_addr_q == cfm_pkg::OFF_INT_EN &&
                 w_strb_q[0]) begin
      int_en_q <= w_data_q[0];
    end
  end

  // Pending bit: a completion in the clearing cycle survives
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      int_st_q <= 1'b0;
    end else begin
      int_st_q <= (int_st_q &&
                   !(wr_fire && aw_addr_q == cfm_pkg::OFF_INT_ST &&
                     w_strb_q[0] && w_data_q[0])) ||
                  (done && int_en_q);
    end
  end

  assign irq = int_st_q;

  // Measurement sequencing
  assign cnt_full = &cnt_q;
  assign done     = (state_q == cfm_pkg::ST_COUNT) && gate_end;
  assign tk.sel   = sel;
  assign cnt_tick = tk.tick;

  always_ff @(posedge ref_clk) begin
    if (rst || !(freq_mode || pw_mode)) begin
      state_q <= cfm_pkg::ST_IDLE;
    end else if (sw_trig || ext_trig) begin
      state_q <= cfm_pkg::ST_ARMED;
    end else begin
      unique case (state_q)
        cfm_pkg::ST_IDLE:  state_q <= cfm_pkg::ST_IDLE;
        cfm_pkg::ST_ARMED:
          if (gate_start) begin
            state_q <= cfm_pkg::ST_COUNT;
          end
        cfm_pkg::ST_COUNT:
          if (gate_end) begin
            state_q <= cfm_pkg::ST_IDLE;
          end
        default: state_q <= cfm_pkg::ST_IDLE;
      endcase
    end
  end

  // Counter; saturates at all ones to flag overflow
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (sw_trig || ext_trig) begin
      cnt_q <= '0;
    end else if (const_wr && state_q == cfm_pkg::ST_COUNT) begin
      cnt_q <= const_new[CNT_W-1:0];
    end else if (state_q == cfm_pkg::ST_COUNT && gate_act && !cnt_full) begin
      if (freq_mode && evt_edge) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pw_mode && cnt_tick) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // Completion pulse on the counter output
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pulse_cnt_q <= '0;
    end else if (done) begin
      pulse_cnt_q <=
        cfm_pkg::OUT_PULSE_CYC[cfm_pkg::OUT_PULSE_W-1:0];
    end else if (pulse_cnt_q != '0) begin
      pulse_cnt_q <= pulse_cnt_q - 1'b1;
    end
  end

  // Reset leaves the output idle high since bit 3 resets to 0
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      counter_out <= 1'b1;
    end else begin
      counter_out <= (pulse_cnt_q != '0) ==
                     ctrl_q[cfm_pkg::CTRL_OPOL_BIT];
    end
  end

  // Read path, one cycle after the address is taken
  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= cfm_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q  <= cfm_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        cfm_pkg::OFF_CTRL:   rdata_q <= {16'h0000, ctrl_q};
        cfm_pkg::OFF_CONST:  rdata_q <= const_q;
        cfm_pkg::OFF_RDBACK:
          rdata_q <= {{(32-CNT_W){1'b0}}, cnt_q};
        cfm_pkg::OFF_TRIG:   rdata_q <= 32'h0000_0000;
        cfm_pkg::OFF_INT_EN: rdata_q <= {31'h0000_0000, int_en_q};
        cfm_pkg::OFF_INT_ST: rdata_q <= {31'h0000_0000, int_st_q};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= cfm_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

endmodule

// ---- verification/cfm_field_model.sv ----
// Field pin source driving gate, event and trigger inputs
`timescale 1ns/1ps
module cfm_field_model (
  // Clock
  input  wire logic ref_clk,
  // Field pins
  output logic      gate_measure_input,
  output logic      event_signal_input,
  output logic      external_trigger_input
);
  initial begin
    gate_measure_input     = 1'b0;
    event_signal_input     = 1'b0;
    external_trigger_input = 1'b0;
  end

  task automatic set_pins(input logic g, input logic e, input logic t);
    @(posedge ref_clk);
    gate_measure_input     <= g;
    event_signal_input     <= e;
    external_trigger_input <= t;
  endtask

  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Each level lasts 8 cycles, 40 ns, above the minimum pulse width
  task automatic events(input int n);
    repeat (2 * n) begin
      @(posedge ref_clk);
      event_signal_input <= !event_signal_input;
      repeat (7) @(posedge ref_clk);
    end
  endtask

  task automatic trig();
    repeat (2) begin
      @(posedge ref_clk);
      external_trigger_input <= !external_trigger_input;
      repeat (7) @(posedge ref_clk);
    end
  endtask
endmodule

// ---- verification/cfm_counter_props.sv ----
// Bus handshake, reset and interrupt checks for the counter channel
`timescale 1ns/1ps
module cfm_counter_props (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // Bus handshake
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Field output and interrupt
  input wire logic        counter_out,
  input wire logic        irq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  chk_reset_idle: assert property ($fell(rst) |-> s_axi_awready &&
    s_axi_wready && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid && !irq)
    else $error("outputs not idle after reset");
  chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("bvalid dropped before bready");
  chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data unstable");
  chk_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address accepted while read pending");
  chk_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready &&
    !s_axi_wready) else $error("write accepted while response pending");
  chk_b_after_both: assert property ($rose(s_axi_bvalid) |->
    $past(!s_axi_awready && !s_axi_wready))
    else $error("response before address and data");
  chk_irq_pending: assert property (irq && s_axi_wready && !s_axi_wvalid |=>
    irq) else $error("interrupt dropped without a write");
  chk_irq_pulse: assert property ($rose(irq) |-> ##[0:1]
    $changed(counter_out)) else $error("no output pulse with interrupt");
endmodule

bind cfm_counter cfm_counter_props chk_u (.ref_clk, .rst, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .counter_out,
  .irq);

// ---- verification/cfm_counter_tb.sv ----
// Register-level testbench for the measurement counter channel
`timescale 1ns/1ps
module cfm_counter_tb;
  // Narrow counter so that overflow is reachable
  localparam int CW = 8;
  logic        ref_clk, rst;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, d2;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, counter_out, irq, gi, ei, ti;
  wire         gate_measure_input, event_signal_input, external_trigger_input;
  int          mismatches, tests_run;
  logic [1:0]  gp [4] = '{2'h2, 2'h1, 2'h2, 2'h2};
  logic [1:0]  ep [4] = '{2'h2, 2'h1, 2'h1, 2'h3};
  logic [1:0]  tp [4] = '{2'h0, 2'h2, 2'h1, 2'h0};
  logic        op [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
  int          nv [4] = '{5, 4, 3, 2};

  cfm_counter #(.CNT_W(CW)) dut_u (.ref_clk, .rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .gate_measure_input, .event_signal_input,
    .external_trigger_input, .counter_out, .irq);
  cfm_field_model fm_u (.ref_clk, .gate_measure_input, .event_signal_input,
    .external_trigger_input);

  always #2.5 ref_clk = ~ref_clk;

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, got;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge ref_clk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      got = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge ref_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (got) s_axi_bready <= 1'b0;
    end while (!got);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    logic ta, got;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge ref_clk);
      ta = s_axi_arready;
      got = s_axi_rvalid;
      v = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge ref_clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (got) s_axi_rready <= 1'b0;
    end while (!got);
  endtask

  // Waits for the completion pulse, then checks its length in cycles
  task automatic pulse_chk(input logic act);
    int n;
    n = 0;
    repeat (60) if (n == 0) begin
      @(negedge ref_clk);
      if (counter_out === act) n = 1;
    end
    while (counter_out === act) begin
      @(negedge ref_clk);
      n++;
    end
    check("pulse_len", 32'(n - 1), cfm_pkg::OUT_PULSE_CYC);
  endtask

  function automatic logic [31:0] cw(logic [2:0] m, logic o,
    logic [1:0] g, logic [1:0] e, logic [1:0] t, logic [2:0] s);
    return {19'h0, s, t, e, g, o, m};
  endfunction

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge ref_clk);
    mismatches++;
    end_of_test();
  end

  initial begin
    ref_clk = 0;
    rst = 1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rd(cfm_pkg::OFF_CTRL, d);
    check("ctrl_reset", d, 32'h0000_0000);
    rd(8'h18, d);
    check("unmapped_rd", {d[29:0], r}, {30'h0, cfm_pkg::RESP_SLVERR});
    wr(8'h18, 32'h0000_0001);
    check("unmapped_wr", r, cfm_pkg::RESP_SLVERR);
    wr(cfm_pkg::OFF_CTRL, 32'hFFFF_FFFF);
    rd(cfm_pkg::OFF_CTRL, d);
    check("ctrl_mask", d, 32'h0000_1FFF);
    wr(cfm_pkg::OFF_INT_EN, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      gi = (gp[i] == cfm_pkg::POL_LOW);
      ei = (ep[i] == cfm_pkg::POL_LOW);
      ti = (tp[i] == cfm_pkg::POL_LOW);
      fm_u.set_pins(gi, ei, ti);
      wr(cfm_pkg::OFF_CTRL, cw(cfm_pkg::MODE_FREQ, op[i], gp[i], ep[i],
        tp[i], cfm_pkg::SEL_FREQ));
      if (tp[i] == 2'h0) wr(cfm_pkg::OFF_TRIG, 32'h0000_0001);
      else fm_u.trig();
      fm_u.events(2);
      fm_u.set_pins(!gi, ei, ti);
      fm_u.events(nv[i]);
      rd(cfm_pkg::OFF_RDBACK, d);
      check("freq_count", d, (ep[i] inside {2'h1, 2'h2}) ? nv[i] : 0);
      fm_u.set_pins(gi, ei, ti);
      pulse_chk(op[i]);
      check("irq_set", irq, 1'b1);
      wr(cfm_pkg::OFF_INT_ST, 32'h0000_0001);
      @(negedge ref_clk);
      check("irq_clear", irq, 1'b0);
    end
    wr(cfm_pkg::OFF_TRIG, 32'h0000_0001);
    fm_u.set_pins(1'b1, 1'b0, 1'b0);
    wr(cfm_pkg::OFF_CONST, 32'h0000_0023);
    rd(cfm_pkg::OFF_RDBACK, d);
    check("const_load", d, 32'h0000_0023);
    fm_u.set_pins(1'b0, 1'b0, 1'b0);
    pulse_chk(1'b0);
    wr(cfm_pkg::OFF_INT_ST, 32'h0000_0001);
    for (int s = 5; s > 3; s--) begin
      wr(cfm_pkg::OFF_CTRL, cw(cfm_pkg::MODE_PW, 1'b0, cfm_pkg::POL_HIGH,
        2'h0, 2'h0, 3'(s)));
      wr(cfm_pkg::OFF_TRIG, 32'h0000_0001);
      fm_u.set_pins(1'b1, 1'b0, 1'b0);
      fm_u.hold(300);
      fm_u.set_pins(1'b0, 1'b0, 1'b0);
      pulse_chk(1'b0);
      rd(cfm_pkg::OFF_RDBACK, d);
      check("pw_width", (s == 4) ? 32'(d >= 99 && d <= 101) : d, 32'(s == 4));
      check("pw_irq", irq, 1'b1);
      wr(cfm_pkg::OFF_INT_ST, 32'h0000_0001);
    end
    fm_u.set_pins(1'b1, 1'b0, 1'b0);
    fm_u.hold(100);
    fm_u.set_pins(1'b0, 1'b0, 1'b0);
    rd(cfm_pkg::OFF_RDBACK, d2);
    check("pw_first_only", d2, d);
    wr(cfm_pkg::OFF_INT_EN, 32'h0000_0000);
    wr(cfm_pkg::OFF_CTRL, cw(cfm_pkg::MODE_PW, 1'b0, cfm_pkg::POL_LOW,
      2'h0, 2'h2, 3'h4));
    fm_u.set_pins(1'b1, 1'b0, 1'b0);
    fm_u.trig();
    fm_u.set_pins(1'b0, 1'b0, 1'b0);
    fm_u.hold(900);
    fm_u.set_pins(1'b1, 1'b0, 1'b0);
    rd(cfm_pkg::OFF_RDBACK, d);
    check("pw_overflow", d, 32'((1 << CW) - 1));
    check("irq_masked", irq, 1'b0);
    end_of_test();
  end
endmodule
